// >>> design/rtcar_alarm_regs.sv
`timescale 1ns/1ps
module rtcar_alarm_regs (
    input  wire logic                        clk,              // system clock, 100 MHz
    input  wire logic                        reset_n,          // async reset, active low
    input  wire logic [rtcar_pkg::ADDR_W-1:0] regAddr,         // register index
    input  wire logic [15:0]                 regWdata,         // write data
    input  wire logic                        regWrite,         // write strobe
    input  wire logic                        regRead,          // read strobe
    output logic      [15:0]                 regRdata,         // read data, cycle after strobe
    input  wire logic                        halfTick,         // half-second boundary pulse
    input  wire logic                        halfSecond,       // high in second half of a second
    input  wire logic                        secondsClock,     // seconds clock from the time base
    output logic                             clkOutPin,        // clock output pin level
    output logic                             clkOutEn,         // clock output pin enable
    output logic                             alarmEvent,       // one-cycle alarm pulse
    output logic                             moduleEnable,     // clock module enable bit
    output logic                             parportBufferSel  // parallel port buffer select
);
    // control registers, reset to defined values
    logic [15:0] calib;        // calib_config_reg
    logic [15:0] pad;          // pad_config
    logic [15:0] alcfg;        // alarm_config
    // value registers, deliberately not reset
    logic [15:0] year;         // time_year_value
    logic [15:0] mday;         // time_month_day_value
    logic [15:0] wkhr;         // time_weekday_hours_value
    logic [15:0] minsec;       // time_minutes_seconds_value
    logic [15:0] almMday;      // alarm month/day
    logic [15:0] almWkhr;      // alarm weekday/hours
    logic [15:0] almMinsec;    // alarm minutes/seconds

    // field views
    logic [1:0] timePtr;       // time_window_pointer
    logic [1:0] almPtr;        // alarm_window_pointer
    logic [7:0] repeatCnt;     // alarm_repeat_count
    logic [3:0] interval;      // alarm_interval
    logic       wren;          // time_write_enable
    logic       oe;            // clk_output_enable
    logic       srcSel;        // clk_out_source_sel

    assign timePtr   = calib[rtcar_pkg::CAL_PTR_LSB +: 2];
    assign almPtr    = alcfg[rtcar_pkg::ALC_PTR_LSB +: 2];
    assign repeatCnt = alcfg[7:0];
    assign interval  = alcfg[rtcar_pkg::ALC_INT_LSB +: 4];
    assign wren      = calib[rtcar_pkg::CAL_WREN_BIT];
    assign oe        = calib[rtcar_pkg::CAL_OE_BIT];
    assign srcSel    = pad[rtcar_pkg::PAD_SECSEL_BIT];

    // address decode
    logic calWr, padWr, alcWr, timeWr, timeRd, alWinWr, alWinRd;
    assign calWr   = regWrite && (regAddr == rtcar_pkg::OFS_CALIB);
    assign padWr   = regWrite && (regAddr == rtcar_pkg::OFS_PAD);
    assign alcWr   = regWrite && (regAddr == rtcar_pkg::OFS_ALCFG);
    assign timeWr  = regWrite && (regAddr == rtcar_pkg::OFS_TIMEWIN);
    assign timeRd  = regRead  && (regAddr == rtcar_pkg::OFS_TIMEWIN);
    assign alWinWr = regWrite && (regAddr == rtcar_pkg::OFS_ALWIN);
    assign alWinRd = regRead  && (regAddr == rtcar_pkg::OFS_ALWIN);

    // pointer step: down by one, parked at 00
    function automatic logic [1:0] ptrStep(input logic [1:0] p);
        ptrStep = (p == rtcar_pkg::PTR_MINSEC) ? p : p - 2'h1;
    endfunction

    // time window read mux; the word port always touches the upper byte too
    function automatic logic [15:0] timeView(input logic [1:0] p);
        case (p)
            rtcar_pkg::PTR_MINSEC: timeView = minsec & rtcar_pkg::MINSEC_MASK;
            rtcar_pkg::PTR_WKHR:   timeView = wkhr & rtcar_pkg::WKHR_MASK;
            rtcar_pkg::PTR_MDAY:   timeView = mday & rtcar_pkg::MDAY_MASK;
            default:               timeView = year & rtcar_pkg::YEAR_MASK;
        endcase
    endfunction

    // alarm window read mux; pointer 11 has no register behind it
    function automatic logic [15:0] alarmView(input logic [1:0] p);
        case (p)
            rtcar_pkg::PTR_MINSEC: alarmView = almMinsec & rtcar_pkg::MINSEC_MASK;
            rtcar_pkg::PTR_WKHR:   alarmView = almWkhr & rtcar_pkg::WKHR_MASK;
            rtcar_pkg::PTR_MDAY:   alarmView = almMday & rtcar_pkg::MDAY_MASK;
            default:               alarmView = 16'h0000;
        endcase
    endfunction

    // field comparisons between time and alarm values
    logic eqSecOne, eqSec, eqMinOne, eqMin, eqHr, eqWd, eqDay, eqMth;
    assign eqSecOne = minsec[3:0] == almMinsec[3:0];
    assign eqSec    = minsec[6:0] == almMinsec[6:0];
    assign eqMinOne = minsec[11:8] == almMinsec[11:8];
    assign eqMin    = minsec[14:8] == almMinsec[14:8];
    assign eqHr     = wkhr[5:0] == almWkhr[5:0];
    assign eqWd     = wkhr[10:8] == almWkhr[10:8];
    assign eqDay    = mday[5:0] == almMday[5:0];
    assign eqMth    = mday[12:8] == almMday[12:8];

    // leap year test on bcd year within one century
    logic leapYear;
    logic feb29Alarm;
    assign leapYear   = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                                : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    assign feb29Alarm = (almMday[12:8] == rtcar_pkg::FEB_CODE) && (almMday[5:0] == rtcar_pkg::DAY29);

    // interval mask: each longer period adds one more field to the compare, except month, which compares the day in place of the weekday
    logic wholeSec;
    logic match;
    assign wholeSec = !halfSecond;
    always_comb begin
        case (interval)
            rtcar_pkg::RTCAR_HALFSEC: match = 1'b1;
            rtcar_pkg::RTCAR_SECOND:  match = wholeSec;
            rtcar_pkg::RTCAR_TENSEC:  match = wholeSec && eqSecOne;
            rtcar_pkg::RTCAR_MINUTE:  match = wholeSec && eqSec;
            rtcar_pkg::RTCAR_TENMIN:  match = wholeSec && eqSec && eqMinOne;
            rtcar_pkg::RTCAR_HOUR:    match = wholeSec && eqSec && eqMin;
            rtcar_pkg::RTCAR_DAY:     match = wholeSec && eqSec && eqMin && eqHr;
            rtcar_pkg::RTCAR_WEEK:    match = wholeSec && eqSec && eqMin && eqHr && eqWd;
            rtcar_pkg::RTCAR_MONTH:   match = wholeSec && eqSec && eqMin && eqHr && eqDay;
            rtcar_pkg::RTCAR_YEAR:    match = wholeSec && eqSec && eqMin && eqHr && eqDay && eqMth
                                              && (!feb29Alarm || leapYear);
            default:                  match = 1'b0;  // reserved codes never fire
        endcase
    end

    // alarm event: only on a half-second boundary, only while enabled
    logic alarmFire;
    assign alarmFire = halfTick && alcfg[rtcar_pkg::ALC_EN_BIT] && match;

    // calibration/config register; module enable bit needs the write enable already set
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            calib <= rtcar_pkg::CAL_RESET;
        end else if (calWr) begin
            calib <= regWdata & rtcar_pkg::CAL_WMASK;
            if (!wren) begin
                calib[rtcar_pkg::CAL_ENABLE_BIT] <= calib[rtcar_pkg::CAL_ENABLE_BIT];
            end
        end else if (timeWr || timeRd) begin
            // every word access of the time window steps its pointer down by one, unless it is already parked at 00
            calib[rtcar_pkg::CAL_PTR_LSB +: 2] <= ptrStep(timePtr);
        end
    end

    // pad configuration register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad <= rtcar_pkg::PAD_RESET;
        end else if (padWr) begin
            pad <= regWdata & rtcar_pkg::PAD_WMASK;
        end
    end

    // alarm configuration; a software write beats the same-cycle hardware update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alcfg <= rtcar_pkg::ALC_RESET;
        end else if (alcWr) begin
            alcfg <= regWdata;
        end else begin
            if (alWinWr || alWinRd) begin
                alcfg[rtcar_pkg::ALC_PTR_LSB +: 2] <= ptrStep(almPtr);
            end
            if (alarmFire) begin
                if (repeatCnt != 8'h00) begin
                    alcfg[7:0] <= repeatCnt - 8'h01;
                end else if (alcfg[rtcar_pkg::ALC_CHIME_BIT]) begin
                    alcfg[7:0] <= rtcar_pkg::REPEAT_WRAP;
                end else begin
                    alcfg[rtcar_pkg::ALC_EN_BIT] <= 1'b0;
                end
            end
        end
    end

    // time value registers; locked unless the write enable bit is set
    always_ff @(posedge clk) begin
        if (timeWr && wren) begin
            case (timePtr)
                rtcar_pkg::PTR_MINSEC: minsec <= regWdata & rtcar_pkg::MINSEC_MASK;
                rtcar_pkg::PTR_WKHR:   wkhr <= regWdata & rtcar_pkg::WKHR_MASK;
                // month digits are read-only here, only the day digits take the write
                rtcar_pkg::PTR_MDAY:   mday <= (mday & ~rtcar_pkg::MDAY_WMASK)
                                               | (regWdata & rtcar_pkg::MDAY_WMASK);
                rtcar_pkg::PTR_YEAR:   year <= regWdata & rtcar_pkg::YEAR_MASK;
                default:               year <= year;
            endcase
        end
    end

    // alarm value registers behind the alarm window
    always_ff @(posedge clk) begin
        if (alWinWr) begin
            case (almPtr)
                rtcar_pkg::PTR_MINSEC: almMinsec <= regWdata & rtcar_pkg::MINSEC_MASK;
                rtcar_pkg::PTR_WKHR:   almWkhr <= regWdata & rtcar_pkg::WKHR_MASK;
                rtcar_pkg::PTR_MDAY:   almMday <= regWdata & rtcar_pkg::MDAY_MASK;
                default:               almMday <= almMday;  // no register at 11
            endcase
        end
    end

    // read data: valid only in the cycle after the read strobe, zero otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                rtcar_pkg::OFS_CALIB:   regRdata <= (calib & rtcar_pkg::CAL_WMASK)
                                                    | ({15'h0000, halfSecond} << rtcar_pkg::CAL_HALF_BIT);
                rtcar_pkg::OFS_PAD:     regRdata <= pad & rtcar_pkg::PAD_WMASK;
                rtcar_pkg::OFS_ALCFG:   regRdata <= alcfg;
                rtcar_pkg::OFS_TIMEWIN: regRdata <= timeView(timePtr);
                rtcar_pkg::OFS_ALWIN:   regRdata <= alarmView(almPtr);
                default:                regRdata <= 16'h0000;  // unmapped index reads zero
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // output pin and alarm pulse, registered so the pin never glitches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clkOutPin  <= 1'b0;
            clkOutEn   <= 1'b0;
            alarmEvent <= 1'b0;
        end else begin
            clkOutPin  <= oe && (srcSel ? secondsClock : alarmFire);
            clkOutEn   <= oe;
            alarmEvent <= alarmFire;
        end
    end

    assign moduleEnable     = calib[rtcar_pkg::CAL_ENABLE_BIT];
    assign parportBufferSel = pad[rtcar_pkg::PAD_BUFSEL_BIT];

    // checks on the guarded behaviour
    a_pin_seconds_src:
    assert property (@(posedge clk) disable iff (!reset_n)
        (oe && srcSel) |=> (clkOutPin == $past(secondsClock)))
        else $error("pin does not follow seconds clock");

    a_pin_alarm_src:
    assert property (@(posedge clk) disable iff (!reset_n)
        (oe && !srcSel) |=> (clkOutPin == $past(alarmFire)) && (alarmEvent == clkOutPin))
        else $error("pin does not follow alarm pulse");

    a_pin_disabled_low:
    assert property (@(posedge clk) disable iff (!reset_n)
        !oe |=> (!clkOutPin && !clkOutEn))
        else $error("pin active while output disabled");

    a_enable_self_clear:
    assert property (@(posedge clk) disable iff (!reset_n)
        (alarmFire && repeatCnt == 8'h00 && !alcfg[rtcar_pkg::ALC_CHIME_BIT] && !alcWr)
        |=> !alcfg[rtcar_pkg::ALC_EN_BIT] && (repeatCnt == 8'h00))
        else $error("alarm enable not cleared at final event");

    a_chime_wrap:
    assert property (@(posedge clk) disable iff (!reset_n)
        (alarmFire && repeatCnt == 8'h00 && alcfg[rtcar_pkg::ALC_CHIME_BIT] && !alcWr)
        |=> (repeatCnt == 8'hFF) && alcfg[rtcar_pkg::ALC_EN_BIT])
        else $error("repeat count did not wrap with chime");

    a_repeat_dec:
    assert property (@(posedge clk) disable iff (!reset_n)
        (alarmFire && repeatCnt != 8'h00 && !alcWr) |=> (repeatCnt == $past(repeatCnt) - 8'h01))
        else $error("repeat count did not decrement");

    a_halfsec_fires:
    assert property (@(posedge clk) disable iff (!reset_n)
        (halfTick && alcfg[rtcar_pkg::ALC_EN_BIT] && interval == 4'h0) |=> alarmEvent)
        else $error("half-second interval missed an event");

    a_feb29_leap:
    assert property (@(posedge clk) disable iff (!reset_n)
        (interval == 4'h9 && feb29Alarm && !leapYear) |-> !alarmFire)
        else $error("february 29th alarm fired outside leap year");

    a_alarm_ptr_step:
    assert property (@(posedge clk) disable iff (!reset_n)
        (alWinWr || alWinRd) |=> (almPtr == (($past(almPtr) == 2'h0) ? 2'h0 : $past(almPtr) - 2'h1)))
        else $error("alarm pointer step wrong");

    a_year_upper_zero:
    assert property (@(posedge clk) disable iff (!reset_n)
        (timeRd && timePtr == rtcar_pkg::PTR_YEAR) |=> (regRdata[15:8] == 8'h00))
        else $error("year upper byte not zero");

    a_time_locked:
    assert property (@(posedge clk) disable iff (!reset_n)
        (timeWr && !wren) |=> $stable(minsec) && $stable(wkhr) && $stable(year))
        else $error("locked time write changed a value register");

    a_pad_upper_zero:
    assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |-> ((pad & ~rtcar_pkg::PAD_WMASK) == 16'h0000))
        else $error("pad unimplemented bits not zero");

    a_rdata_idle_zero:
    assert property (@(posedge clk) disable iff (!reset_n)
        !regRead |=> (regRdata == 16'h0000))
        else $error("read data not zero outside read cycle");

    a_minsec_unused_zero:
    assert property (@(posedge clk) disable iff (!reset_n)
        (timeRd && timePtr == rtcar_pkg::PTR_MINSEC) |=> (!regRdata[15] && !regRdata[7]))
        else $error("minutes/seconds unused bits not zero");

    a_wkhr_unused_zero:
    assert property (@(posedge clk) disable iff (!reset_n)
        (timeRd && timePtr == rtcar_pkg::PTR_WKHR) |=> (regRdata[15:11] == 5'h00) && (regRdata[7:6] == 2'h0))
        else $error("weekday/hours unused bits not zero");

    a_alarm_ptr_empty:
    assert property (@(posedge clk) disable iff (!reset_n)
        (alWinRd && almPtr == 2'h3) |=> (regRdata == 16'h0000))
        else $error("alarm window at pointer 11 not zero");

    a_time_ptr_step:
    assert property (@(posedge clk) disable iff (!reset_n)
        (timeWr || timeRd) |=> (timePtr == (($past(timePtr) == 2'h0) ? 2'h0 : $past(timePtr) - 2'h1)))
        else $error("time pointer step wrong");

    a_event_needs_enable:
    assert property (@(posedge clk) disable iff (!reset_n)
        !alcfg[rtcar_pkg::ALC_EN_BIT] |=> !alarmEvent)
        else $error("alarm event while alarm disabled");
endmodule

// >>> design/rtcar_pkg.sv
// shared constants for the calendar clock alarm and time value register block
package rtcar_pkg;
    // register indices on the plain register port
    localparam int         ADDR_W      = 3;
    localparam logic [2:0] OFS_CALIB   = 3'h0;   // calib_config_reg
    localparam logic [2:0] OFS_PAD     = 3'h1;   // pad_config
    localparam logic [2:0] OFS_ALCFG   = 3'h2;   // alarm_config
    localparam logic [2:0] OFS_TIMEWIN = 3'h3;   // time value window
    localparam logic [2:0] OFS_ALWIN   = 3'h4;   // alarm value window

    // calib_config_reg fields
    localparam int CAL_ENABLE_BIT = 15;
    localparam int CAL_WREN_BIT   = 13;
    localparam int CAL_HALF_BIT   = 11;
    localparam int CAL_OE_BIT     = 10;
    localparam int CAL_PTR_LSB    = 8;
    localparam logic [15:0] CAL_WMASK = 16'hA7FF;   // enable, wren, oe, pointer, calibration
    localparam logic [15:0] CAL_RESET = 16'h0000;

    // pad_config fields
    localparam int          PAD_SECSEL_BIT = 1;
    localparam int          PAD_BUFSEL_BIT = 0;
    localparam logic [15:0] PAD_WMASK      = 16'h0003;
    localparam logic [15:0] PAD_RESET      = 16'h0000;

    // alarm_config fields
    localparam int          ALC_EN_BIT    = 15;
    localparam int          ALC_CHIME_BIT = 14;
    localparam int          ALC_INT_LSB   = 10;
    localparam int          ALC_PTR_LSB   = 8;
    localparam logic [15:0] ALC_RESET     = 16'h0000;
    localparam logic [7:0]  REPEAT_WRAP   = 8'hFF;

    // implemented bits of the value registers
    localparam logic [15:0] YEAR_MASK   = 16'h00FF;
    localparam logic [15:0] MDAY_MASK   = 16'h1F3F;
    localparam logic [15:0] MDAY_WMASK  = 16'h003F;   // month digits are counter-owned in the time window
    localparam logic [15:0] WKHR_MASK   = 16'h073F;
    localparam logic [15:0] MINSEC_MASK = 16'h7F7F;

    // window pointer codes
    localparam logic [1:0] PTR_MINSEC = 2'h0;
    localparam logic [1:0] PTR_WKHR   = 2'h1;
    localparam logic [1:0] PTR_MDAY   = 2'h2;
    localparam logic [1:0] PTR_YEAR   = 2'h3;

    // february 29th in packed month/day form
    localparam logic [4:0] FEB_CODE  = 5'h02;
    localparam logic [5:0] DAY29     = 6'h29;

    // alarm interval codes
    typedef enum logic [3:0] {
        RTCAR_HALFSEC = 4'b0000,
        RTCAR_SECOND  = 4'b0001,
        RTCAR_TENSEC  = 4'b0010,
        RTCAR_MINUTE  = 4'b0011,
        RTCAR_TENMIN  = 4'b0100,
        RTCAR_HOUR    = 4'b0101,
        RTCAR_DAY     = 4'b0110,
        RTCAR_WEEK    = 4'b0111,
        RTCAR_MONTH   = 4'b1000,
        RTCAR_YEAR    = 4'b1001
    } rtcar_interval_e;
endpackage

// >>> testbench/tb_rtcar_alarm_regs.sv
`timescale 1ns/1ps
module tb_rtcar_alarm_regs;
    // one ordinary case: point the window, write, point again, read back
    typedef struct {
        logic [2:0]  ofs;    // register index
        logic [1:0]  ptr;    // window pointer set before each access
        logic [15:0] wdata;  // value written
        logic [15:0] exp;    // value expected on read
    } rtcar_row_s;

    logic        clk;              // 100 MHz bench clock
    logic        reset_n;          // async reset, active low
    logic [2:0]  regAddr;          // register index
    logic [15:0] regWdata;         // write data
    logic        regWrite;         // write strobe
    logic        regRead;          // read strobe
    logic [15:0] regRdata;         // read data
    logic        halfTick;         // half-second boundary pulse
    logic        halfSecond;       // second-half level
    logic        secondsClock;     // seconds clock level
    logic        clkOutPin;        // clock output pin
    logic        clkOutEn;         // clock output enable
    logic        alarmEvent;       // alarm pulse
    logic        moduleEnable;     // module enable bit
    logic        parportBufferSel; // buffer select bit
    logic [15:0] got;              // last read value
    int          n_errors;         // mismatches
    int          n_checks;         // comparisons
    rtcar_row_s  rows[8];          // ordinary cases

    rtcar_alarm_regs rtcar_alarm_regs_i (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .halfTick(halfTick),
        .halfSecond(halfSecond), .secondsClock(secondsClock), .clkOutPin(clkOutPin),
        .clkOutEn(clkOutEn), .alarmEvent(alarmEvent), .moduleEnable(moduleEnable),
        .parportBufferSel(parportBufferSel)
    );

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] act);
        n_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, act);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic act);
        n_checks++;
        if (act !== exp) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, exp, act);
        end
    endtask

    // one-cycle write strobe, launched right after an edge
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so sample there
    task automatic rdchk(input logic [2:0] a, input logic [15:0] exp, input string name);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 got = regRdata;
        chk16(name, exp, got);
    endtask

    // point a window; calib keeps write enable and output enable set
    task automatic setPtr(input logic [2:0] ofs, input logic [1:0] p);
        if (ofs == rtcar_pkg::OFS_TIMEWIN) begin
            wr(rtcar_pkg::OFS_CALIB, {6'h09, p, 8'h00});
        end else if (ofs == rtcar_pkg::OFS_ALWIN) begin
            wr(rtcar_pkg::OFS_ALCFG, {6'h00, p, 8'h00});
        end
    endtask

    // one half-second tick; pad routes the alarm to the enabled pin here
    task automatic tick(input logic expEv);
        @(posedge clk);
        halfTick <= 1'b1;
        @(posedge clk);
        halfTick <= 1'b0;
        #1;
        chk1("alarmEvent", expEv, alarmEvent);
        chk1("clkOutPin", expEv, clkOutPin);
        @(posedge clk);
        #1;
        chk1("alarmEvent low", 1'b0, alarmEvent);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    initial begin
        #1ms;
        n_errors++;
        report_and_stop();
    end

    initial begin
        reset_n = 1'b0;
        regAddr = 3'h0;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        halfTick = 1'b0;
        halfSecond = 1'b0;
        secondsClock = 1'b0;
        n_errors = 0;
        n_checks = 0;
        rows[0] = '{rtcar_pkg::OFS_PAD, 2'h0, 16'hFFFF, 16'h0003};     // pad bits only
        rows[1] = '{rtcar_pkg::OFS_TIMEWIN, 2'h3, 16'hAB99, 16'h0099}; // year
        rows[2] = '{rtcar_pkg::OFS_TIMEWIN, 2'h1, 16'hFF23, 16'h0723}; // weekday/hours
        rows[3] = '{rtcar_pkg::OFS_TIMEWIN, 2'h0, 16'hD959, 16'h5959}; // minutes/seconds
        rows[4] = '{rtcar_pkg::OFS_ALWIN, 2'h2, 16'hF231, 16'h1231};   // alarm month/day
        rows[5] = '{rtcar_pkg::OFS_ALWIN, 2'h1, 16'hFE29, 16'h0629};   // alarm weekday/hours
        rows[6] = '{rtcar_pkg::OFS_ALWIN, 2'h0, 16'hA5D9, 16'h2559};   // alarm minutes/seconds
        rows[7] = '{rtcar_pkg::OFS_ALWIN, 2'h3, 16'hFFFF, 16'h0000};   // no register there
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk1("clkOutEn", 1'b0, clkOutEn);
        chk1("moduleEnable", 1'b0, moduleEnable);
        rdchk(rtcar_pkg::OFS_CALIB, rtcar_pkg::CAL_RESET, "calib reset");
        rdchk(rtcar_pkg::OFS_PAD, rtcar_pkg::PAD_RESET, "pad reset");
        rdchk(rtcar_pkg::OFS_ALCFG, rtcar_pkg::ALC_RESET, "alarm_config reset");
        // ordinary cases
        foreach (rows[i]) begin
            setPtr(rows[i].ofs, rows[i].ptr);
            wr(rows[i].ofs, rows[i].wdata);
            setPtr(rows[i].ofs, rows[i].ptr);
            rdchk(rows[i].ofs, rows[i].exp, "row readback");
        end
        // pointer steps on window access and stops at zero
        setPtr(rtcar_pkg::OFS_ALWIN, 2'h2);
        rdchk(rtcar_pkg::OFS_ALWIN, 16'h1231, "alarm window");
        rdchk(rtcar_pkg::OFS_ALCFG, 16'h0100, "pointer after read");
        wr(rtcar_pkg::OFS_ALWIN, 16'h0310);
        rdchk(rtcar_pkg::OFS_ALWIN, 16'h2559, "alarm window at 00");
        rdchk(rtcar_pkg::OFS_ALCFG, 16'h0000, "pointer held at 00");
        // locked time window ignores writes; enable bit cannot be set while locked
        wr(rtcar_pkg::OFS_CALIB, 16'h0000);
        wr(rtcar_pkg::OFS_CALIB, 16'h8000);
        #1 chk1("moduleEnable locked", 1'b0, moduleEnable);
        wr(rtcar_pkg::OFS_TIMEWIN, 16'h0111);
        setPtr(rtcar_pkg::OFS_TIMEWIN, 2'h0);
        rdchk(rtcar_pkg::OFS_TIMEWIN, 16'h5959, "locked write");
        wr(rtcar_pkg::OFS_CALIB, 16'hA400);
        rdchk(rtcar_pkg::OFS_CALIB, 16'hA400, "calib");
        chk1("moduleEnable", 1'b1, moduleEnable);
        chk1("clkOutEn", 1'b1, clkOutEn);
        // unmapped index
        wr(3'h7, 16'hFFFF);
        rdchk(3'h5, 16'h0000, "unmapped");
        // pin source: seconds clock, then output disabled
        wr(rtcar_pkg::OFS_PAD, 16'h0003);
        secondsClock <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk1("clkOutPin seconds", 1'b1, clkOutPin);
        chk1("parportBufferSel", 1'b1, parportBufferSel);
        wr(rtcar_pkg::OFS_CALIB, 16'hA000);
        repeat (2) @(posedge clk);
        #1 chk1("clkOutPin disabled", 1'b0, clkOutPin);
        chk1("clkOutEn off", 1'b0, clkOutEn);
        wr(rtcar_pkg::OFS_CALIB, 16'hA400);
        wr(rtcar_pkg::OFS_PAD, 16'h0000);
        // time and alarm values that match: day 15, weekday 3, 10 h, 25:59
        setPtr(rtcar_pkg::OFS_TIMEWIN, 2'h2);
        wr(rtcar_pkg::OFS_TIMEWIN, 16'h0015);
        wr(rtcar_pkg::OFS_TIMEWIN, 16'h0310);
        wr(rtcar_pkg::OFS_TIMEWIN, 16'h2559);
        setPtr(rtcar_pkg::OFS_ALWIN, 2'h2);
        wr(rtcar_pkg::OFS_ALWIN, 16'h0115);
        wr(rtcar_pkg::OFS_ALWIN, 16'h0310);
        wr(rtcar_pkg::OFS_ALWIN, 16'h2559);
        // repeat count runs down, then enable clears
        wr(rtcar_pkg::OFS_ALCFG, 16'h8002);
        tick(1'b1);
        rdchk(rtcar_pkg::OFS_ALCFG, 16'h8001, "count 1");
        tick(1'b1);
        tick(1'b1);
        rdchk(rtcar_pkg::OFS_ALCFG, 16'h0000, "self clear");
        tick(1'b0);
        wr(rtcar_pkg::OFS_ALCFG, 16'hC000);
        tick(1'b1);
        rdchk(rtcar_pkg::OFS_ALCFG, 16'hC0FF, "chime wrap");
        // every interval code except year (9), plus reserved 10, with a full match, then seconds ones off by one
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 11; c++) begin
                if (c != 9) begin
                    wr(rtcar_pkg::OFS_ALCFG, {2'b10, c[3:0], 10'h000});
                    tick((m == 0) ? (c < 9) : (c < 2));
                end
            end
            setPtr(rtcar_pkg::OFS_TIMEWIN, 2'h0);
            wr(rtcar_pkg::OFS_TIMEWIN, 16'h2558);
        end
        // second half of a second: only the half-second code fires
        halfSecond <= 1'b1;
        wr(rtcar_pkg::OFS_ALCFG, 16'h8400);
        tick(1'b0);
        wr(rtcar_pkg::OFS_ALCFG, 16'h8000);
        tick(1'b1);
        // mid-run reset clears the control registers and drops the pin enable
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk1("clkOutEn after reset", 1'b0, clkOutEn);
        chk1("parportBufferSel after reset", 1'b0, parportBufferSel);
        rdchk(rtcar_pkg::OFS_ALCFG, rtcar_pkg::ALC_RESET, "alarm_config reset 2");
        rdchk(rtcar_pkg::OFS_PAD, rtcar_pkg::PAD_RESET, "pad reset 2");
        report_and_stop();
    end
endmodule
